// ===== include/tmc_pkg.sv
// Package for the 16-bit timer/counter: register map, control layout,
// reset values and phase constants.
// Assumes a byte-wide register port and one core clock at 100 MHz.
package tmc_pkg;

  localparam logic [7:0] TMC_FLAG_OFS = 8'h0C;
  localparam logic [7:0] TMC_CNTLO_OFS = 8'h0E;
  localparam logic [7:0] TMC_CNTHI_OFS = 8'h0F;
  localparam logic [7:0] TMC_CTRL_OFS = 8'h10;
  localparam logic [7:0] TMC_IE_OFS = 8'h8C;

  localparam logic [5:0] TMC_CTRL_RST = 6'h00;
  localparam logic TMC_FLAG_RST = 1'b0;
  localparam logic TMC_IE_RST = 1'b0;
  localparam logic [15:0] TMC_COUNT_MAX = 16'hFFFF;
  localparam logic [2:0] TMC_PRES_RST = 3'h0;

  // Four core clocks per instruction cycle, phases Q1..Q4 as 0..3
  localparam logic [1:0] TMC_Q2 = 2'h1;
  localparam logic [1:0] TMC_Q4 = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } tmc_req_t;

  // Bit 5..0 of timer_control, in register order
  typedef struct packed {
    logic [1:0] prescaleSelect;
    logic oscEnable;
    logic syncBypass;
    logic sourceSelect;
    logic runEnable;
  } tmc_ctrl_t;

endpackage

// ===== core/tmc_timer.sv
// 16-bit timer/counter with prescaler, optional input synchroniser,
// overflow flag and compare-unit clear.
// Assumes pins arrive asynchronous to clk; rst is power-on/brown-out.
`timescale 1ns/1ns

module tmc_timer
  import tmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire tmc_req_t busReq,
  output logic [7:0] rdData,
  input wire logic extCountPin,
  input wire logic oscInPin,
  input wire logic [1:0] portDirIn,
  input wire logic sleepMode,
  input wire logic ccpReset,
  output logic [1:0] pinOe,
  output logic irqReq,
  output logic wakeReq,
  output logic timeBaseValid
);

  tmc_ctrl_t ctrl_ff, nxt_ctrl;
  logic flag_ff, nxt_flag;
  logic ie_ff, nxt_ie;
  logic [7:0] rdData_ff, nxt_rdData;
  logic [15:0] count_ff, nxt_count;
  logic [1:0] pinMeta_ff, pinSync_ff;
  logic srcPrev_ff, nxt_srcPrev;
  logic [2:0] pres_ff, nxt_pres;
  logic presPrev_ff, nxt_presPrev;
  logic samp_ff, nxt_samp;
  logic sampPrev_ff, nxt_sampPrev;
  logic pend_ff, nxt_pend;
  logic [1:0] qPhase_ff, nxt_qPhase;

  logic wrLo, wrHi, wrCount, wrCtrl, wrFlag, wrIe;
  logic extMode, asyncMode, tick, srcPin, srcRise;
  logic presOut, presWrap, advance, inc, ccpClr, overflow;
  logic [2:0] presMask;

  always_comb begin
    wrLo = busReq.wr && busReq.addr == TMC_CNTLO_OFS;
    wrHi = busReq.wr && busReq.addr == TMC_CNTHI_OFS;
    wrCtrl = busReq.wr && busReq.addr == TMC_CTRL_OFS;
    wrFlag = busReq.wr && busReq.addr == TMC_FLAG_OFS;
    wrIe = busReq.wr && busReq.addr == TMC_IE_OFS;
    wrCount = wrLo || wrHi;
  end

  // Source selection and prescaler
  always_comb begin
    extMode = ctrl_ff.sourceSelect;
    asyncMode = extMode && ctrl_ff.syncBypass;
    tick = qPhase_ff == TMC_Q4 && !sleepMode;
    srcPin = ctrl_ff.oscEnable ? pinSync_ff[1] : pinSync_ff[0];
    srcRise = srcPin && !srcPrev_ff;
    nxt_srcPrev = srcPin;
    case (ctrl_ff.prescaleSelect)
      2'h0: presMask = 3'h0;
      2'h1: presMask = 3'h1;
      2'h2: presMask = 3'h3;
      default: presMask = 3'h7;
    endcase
    presWrap = (pres_ff & presMask) == presMask;
    case (ctrl_ff.prescaleSelect)
      2'h0: presOut = srcPin;
      2'h1: presOut = pres_ff[0];
      2'h2: presOut = pres_ff[1];
      default: presOut = pres_ff[2];
    endcase
    // Prescaler keeps stepping on pin edges even in sleep
    if (wrCount) begin
      nxt_pres = TMC_PRES_RST;
    end else if (extMode ? srcRise : tick) begin
      nxt_pres = pres_ff + 3'h1;
    end else begin
      nxt_pres = pres_ff;
    end
    nxt_presPrev = presOut;
  end

  // Q-phase sampler: the only path for synced external counting
  always_comb begin
    nxt_qPhase = qPhase_ff + 2'h1;
    nxt_samp = samp_ff;
    // Sampler clock stops in sleep, so synced mode freezes
    if ((qPhase_ff == TMC_Q2 || qPhase_ff == TMC_Q4) && !sleepMode) begin
      nxt_samp = presOut;
    end
    nxt_sampPrev = samp_ff;
    nxt_pend = extMode && !asyncMode && samp_ff && !sampPrev_ff;
  end

  always_comb begin
    if (!extMode) begin
      advance = tick && presWrap;
    end else if (asyncMode) begin
      advance = presOut && !presPrev_ff;
    end else begin
      advance = pend_ff;
    end
    inc = ctrl_ff.runEnable && advance;
    ccpClr = ccpReset && !asyncMode;
    overflow = inc && count_ff == TMC_COUNT_MAX && !wrCount && !ccpClr;
    nxt_count = count_ff;
    if (wrLo) begin
      nxt_count[7:0] = busReq.wrData;
    end else if (wrHi) begin
      nxt_count[15:8] = busReq.wrData;
    end else if (ccpClr) begin
      nxt_count = '0;
    end else if (inc) begin
      nxt_count = count_ff + 16'h0001;
    end
  end

  // Register file
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ie = ie_ff;
    if (wrCtrl) begin
      nxt_ctrl = tmc_ctrl_t'(busReq.wrData[5:0]);
    end
    if (wrIe) begin
      nxt_ie = busReq.wrData[0];
    end
    // A wrap in the same cycle as a software clear keeps the flag
    nxt_flag = overflow || (wrFlag ? busReq.wrData[0] : flag_ff);
    nxt_rdData = 8'h00;
    if (busReq.rd) begin
      case (busReq.addr)
        TMC_CNTLO_OFS: nxt_rdData = count_ff[7:0];
        TMC_CNTHI_OFS: nxt_rdData = count_ff[15:8];
        TMC_CTRL_OFS: nxt_rdData = {2'b00, ctrl_ff};
        TMC_FLAG_OFS: nxt_rdData = {7'h00, flag_ff};
        TMC_IE_OFS: nxt_rdData = {7'h00, ie_ff};
        default: nxt_rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= tmc_ctrl_t'(TMC_CTRL_RST);
      flag_ff <= TMC_FLAG_RST;
      ie_ff <= TMC_IE_RST;
      rdData_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      flag_ff <= nxt_flag;
      ie_ff <= nxt_ie;
      rdData_ff <= nxt_rdData;
    end
  end

  // Count survives rst by design; only ccpClr (ccpReset outside async mode) clears it
  always_ff @(posedge clk) begin
    count_ff <= nxt_count;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pinMeta_ff <= 2'h0;
      pinSync_ff <= 2'h0;
      srcPrev_ff <= 1'b0;
      pres_ff <= TMC_PRES_RST;
      presPrev_ff <= 1'b0;
      samp_ff <= 1'b0;
      sampPrev_ff <= 1'b0;
      pend_ff <= 1'b0;
      qPhase_ff <= 2'h0;
    end else begin
      pinMeta_ff <= {oscInPin, extCountPin};
      pinSync_ff <= pinMeta_ff;
      srcPrev_ff <= nxt_srcPrev;
      pres_ff <= nxt_pres;
      presPrev_ff <= nxt_presPrev;
      samp_ff <= nxt_samp;
      sampPrev_ff <= nxt_sampPrev;
      pend_ff <= nxt_pend;
      qPhase_ff <= nxt_qPhase;
    end
  end

  assign rdData = rdData_ff;
  assign irqReq = flag_ff && ie_ff;
  assign wakeReq = irqReq && sleepMode && asyncMode;
  assign timeBaseValid = !asyncMode;
  // Direction bit 1 means input; enable high while driving
  assign pinOe = ctrl_ff.oscEnable ? 2'b00 : ~portDirIn;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence quietCount;
    !wrCount && !ccpClr;
  endsequence

  sequence lowWrite;
    wrLo ##0 ccpReset;
  endsequence

  count_wrap_a: assert property (
    inc && count_ff == TMC_COUNT_MAX && !wrCount && !ccpClr
    |=> count_ff == 16'h0000)
    else $error("count did not wrap to zero");

  flag_set_a: assert property (
    overflow |=> flag_ff ##1 (flag_ff || $past(wrFlag)))
    else $error("overflow flag not held");

  irq_gate_a: assert property (
    $rose(flag_ff) && ie_ff |-> irqReq)
    else $error("enabled overflow gave no request");

  run_hold_a: assert property (
    !ctrl_ff.runEnable and quietCount |=> $stable(count_ff))
    else $error("count moved while stopped");

  timer_rate_a: assert property (
    ctrl_ff.runEnable && !extMode && !sleepMode && tick &&
    ctrl_ff.prescaleSelect == 2'h0 and quietCount
    |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("timer mode missed a tick");

  pres_ratio_a: assert property (
    inc && !extMode && ctrl_ff.prescaleSelect == 2'h3 |-> pres_ff == 3'h7)
    else $error("1:8 prescale stepped early");

  osc_input_a: assert property (
    ctrl_ff.oscEnable |-> pinOe == 2'b00)
    else $error("pin driven with oscillator on");

  sync_sleep_a: assert property (
    sleepMode && extMode && !asyncMode [*4] ##0 quietCount
    |=> $stable(count_ff))
    else $error("synced counter moved in sleep");

  sync_delay_a: assert property (
    nxt_pend && ctrl_ff.runEnable
    ##1 ((ctrl_ff.runEnable && extMode && !asyncMode) and quietCount)
    |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("sampled edge did not count");

  async_base_a: assert property (
    asyncMode |-> !timeBaseValid ##0 !ccpClr)
    else $error("async mode offered as time base");

  ccp_clear_a: assert property (
    ccpClr && !wrCount && !wrFlag |=> count_ff == 16'h0000 && !$rose(flag_ff))
    else $error("compare clear wrong");

  write_wins_a: assert property (
    lowWrite |=> count_ff[7:0] == $past(busReq.wrData) && pres_ff == 3'h0)
    else $error("write lost to compare clear");

  async_wake_a: assert property (
    overflow && asyncMode && sleepMode && ie_ff ##1 sleepMode |-> wakeReq)
    else $error("async overflow did not wake");

  pres_clear_a: assert property (
    wrCount |=> pres_ff == TMC_PRES_RST)
    else $error("count write left prescaler");

  flag_clear_a: assert property (
    wrFlag && !busReq.wrData[0] && !overflow |=> !flag_ff)
    else $error("flag clear ignored");

  ccp_async_a: assert property (
    ccpReset && asyncMode && !wrCount && !inc |=> $stable(count_ff))
    else $error("compare clear hit async counter");

  pres_sleep_a: assert property (
    extMode && sleepMode && srcRise && !wrCount
    |=> pres_ff == $past(pres_ff) + 3'h1)
    else $error("prescaler stopped in sleep");

  async_sleep_a: assert property (
    asyncMode && sleepMode && ctrl_ff.runEnable && presOut && !presPrev_ff
    && !wrCount && !ccpClr |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("async counter stalled in sleep");

endmodule

// ===== dv/tmc_clk_src.sv
// Far-side count source: drives either the ext pin or the osc pin.
// Assumes the bench calls burst() and picks the pin with useOsc.
`timescale 1ns/1ns
module tmc_clk_src (
  input wire logic useOsc,
  output logic extPin,
  output logic oscPin
);
  logic lvl = 1'b0;
  // Unused pin sits at its pull-down level
  assign extPin = useOsc ? 1'b0 : lvl;
  assign oscPin = useOsc ? lvl : 1'b0;
  // 63/62 ns phases, period 125 ns; idle low between bursts
  task automatic burst(input int n);
    repeat (n) begin
      #63 lvl = 1'b1;
      #62 lvl = 1'b0;
    end
  endtask
endmodule

// ===== dv/tmc_timer_tb_top.sv
// Self-checking bench: reset, then table of count modes, wrap,
// compare clear, sleep and prescaler cases. Uses dv/tmc_clk_src.sv.
`timescale 1ns/1ns
module tmc_timer_tb_top;
  import tmc_pkg::*;
  typedef struct {
    logic [7:0] ctrl;
    int n;
    logic [7:0] exp;
  } tmc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  tmc_req_t busReq = '0;
  logic [7:0] rdData;
  logic [7:0] a;
  logic [7:0] b;
  logic extPin;
  logic oscPin;
  logic useOsc = 1'b0;
  logic [1:0] portDirIn = 2'b01;
  logic sleepMode = 1'b0;
  logic ccpReset = 1'b0;
  logic [1:0] pinOe;
  logic irqReq;
  logic wakeReq;
  logic timeBaseValid;
  int nTests = 0;
  int nMismatch = 0;
  // Internal rows: n is read spacing in clocks; external: n pin edges
  tmc_row_t rows [12] = '{
    '{8'h01, 40, 8'h0A}, '{8'h11, 80, 8'h0A}, '{8'h21, 160, 8'h0A},
    '{8'h31, 320, 8'h0A}, '{8'h05, 40, 8'h0A}, '{8'h03, 10, 8'h0A},
    '{8'h13, 10, 8'h05}, '{8'h23, 16, 8'h04}, '{8'h33, 16, 8'h02},
    '{8'h07, 6, 8'h06}, '{8'h0B, 7, 8'h07}, '{8'h02, 5, 8'h00}
  };
  logic [7:0] zAdr [4] = '{TMC_CTRL_OFS, TMC_FLAG_OFS, TMC_IE_OFS, 8'h55};

  always #5 clk = ~clk;

  tmc_timer uut (
    .clk(clk), .rst(rst), .busReq(busReq), .rdData(rdData),
    .extCountPin(extPin), .oscInPin(oscPin), .portDirIn(portDirIn),
    .sleepMode(sleepMode), .ccpReset(ccpReset), .pinOe(pinOe),
    .irqReq(irqReq), .wakeReq(wakeReq), .timeBaseValid(timeBaseValid)
  );

  tmc_clk_src src (.useOsc(useOsc), .extPin(extPin), .oscPin(oscPin));

  task automatic chk(input string nm, input logic [15:0] e, g);
    nTests++;
    if (g !== e) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrReg(input logic [7:0] ad, dt);
    @(posedge clk);
    busReq <= '{addr: ad, wrData: dt, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
    #1;
  endtask

  task automatic rdReg(input logic [7:0] ad, output logic [7:0] d);
    @(posedge clk);
    busReq <= '{addr: ad, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    #1 d = rdData;
  endtask

  task automatic ccpPulse;
    @(posedge clk);
    ccpReset <= 1'b1;
    @(posedge clk);
    ccpReset <= 1'b0;
    #1;
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Run needs about 20 us; this leaves a wide margin
  initial begin
    #300000;
    nMismatch++;
    conclude();
  end

  initial begin
    // Count has no reset: load it while reset still holds
    repeat (12) @(posedge clk);
    wrReg(TMC_CNTLO_OFS, 8'h00);
    wrReg(TMC_CNTHI_OFS, 8'h00);
    rst <= 1'b0;
    foreach (zAdr[i]) begin
      rdReg(zAdr[i], a);
      chk("rstReg", 8'h00, a);
    end
    $display("reset test done");
    foreach (rows[i]) begin
      useOsc <= rows[i].ctrl[3];
      portDirIn <= 2'(i);
      wrReg(TMC_CNTLO_OFS, 8'h00);
      wrReg(TMC_CNTHI_OFS, 8'h00);
      wrReg(TMC_CTRL_OFS, rows[i].ctrl);
      chk("pinOe", rows[i].ctrl[3] ? 2'b00 : {~portDirIn}, pinOe);
      chk("timeBase", {~(rows[i].ctrl[1] & rows[i].ctrl[2])},
          timeBaseValid);
      rdReg(TMC_CNTLO_OFS, a);
      if (rows[i].ctrl[1]) begin
        src.burst(rows[i].n);
        repeat (12) @(posedge clk);
      end else begin
        repeat (rows[i].n - 2) @(posedge clk);
      end
      rdReg(TMC_CNTLO_OFS, b);
      chk("countStep", rows[i].exp, b - a);
      $display("row %0d done", i);
    end
    wrReg(TMC_IE_OFS, 8'h01);
    wrReg(TMC_CNTLO_OFS, 8'hFF);
    wrReg(TMC_CNTHI_OFS, 8'hFF);
    wrReg(TMC_CTRL_OFS, 8'h03);
    src.burst(1);
    repeat (12) @(posedge clk);
    rdReg(TMC_CNTHI_OFS, a);
    chk("wrapHigh", 8'h00, a);
    chk("irq", 1'b1, irqReq);
    src.burst(1);
    repeat (12) @(posedge clk);
    rdReg(TMC_FLAG_OFS, b);
    chk("flagHeld", 8'h01, b);
    wrReg(TMC_FLAG_OFS, 8'h00);
    chk("irqClear", 1'b0, irqReq);
    ccpPulse();
    rdReg(TMC_CNTLO_OFS, a);
    rdReg(TMC_FLAG_OFS, b);
    chk("ccpClear", 8'h00, a);
    chk("ccpFlag", 8'h00, b);
    fork
      wrReg(TMC_CNTLO_OFS, 8'h5A);
      ccpPulse();
    join
    rdReg(TMC_CNTLO_OFS, a);
    chk("writeWins", 8'h5A, a);
    $display("wrap and clear test done");
    sleepMode <= 1'b1;
    src.burst(4);
    repeat (12) @(posedge clk);
    rdReg(TMC_CNTLO_OFS, a);
    chk("syncSleep", 8'h5A, a);
    wrReg(TMC_CTRL_OFS, 8'h07);
    wrReg(TMC_CNTLO_OFS, 8'hFF);
    wrReg(TMC_CNTHI_OFS, 8'hFF);
    src.burst(1);
    repeat (12) @(posedge clk);
    chk("wake", 1'b1, wakeReq);
    sleepMode <= 1'b0;
    $display("sleep test done");
    wrReg(TMC_CTRL_OFS, 8'h13);
    wrReg(TMC_CNTLO_OFS, 8'h00);
    src.burst(1);
    wrReg(TMC_CNTLO_OFS, 8'h00);
    src.burst(1);
    repeat (12) @(posedge clk);
    rdReg(TMC_CNTLO_OFS, a);
    chk("presClear", 8'h01, a);
    wrReg(TMC_CTRL_OFS, 8'hFF);
    rdReg(TMC_CTRL_OFS, a);
    chk("ctrlBits", 8'h3F, a);
    wrReg(TMC_CNTLO_OFS, 8'h12);
    ccpPulse();
    wrReg(TMC_CNTHI_OFS, 8'h34);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdReg(TMC_CNTLO_OFS, a);
    rdReg(TMC_CNTHI_OFS, b);
    chk("countKept", 16'h3412, {b, a});
    rdReg(TMC_CTRL_OFS, a);
    chk("ctrlReset", 8'h00, a);
    $display("prescaler and reset test done");
    conclude();
  end
endmodule
